// ==== design/pwmb_bank.v ====
// Four waveform outputs with their register bank on the controller bus
`timescale 1ns/1ps
`include "pwmb_consts.vh"

// Function
// - Three registers per instance at 00h/04h/08h.
// - Four instances, 10h apart, from 4000_5800h.
// - High count zero, low nonzero: output off.
// - Low count zero: output held fully on.
// - 16-bit counts; reset high 0000h, low FFFFh.
// - Config bit 1 picks slow or fast clock.
// - Count rate is source over prescaler plus one.
// - Config bit 2 inverts on-phase level.
// - Disable gates ticks, clears counters and state.
// - Disabled output sits at inactive level.
// - Counts unaffected by enable, always accessible.
// - Configuration resets to all zero.
// - Fast is ring oscillator, slow 100 kHz.
// - Period is tick period times count sum.
// - Duty is high count over count sum.
// - Sleep clears counters and forces output off.
module pwmb_bank (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Controller register port
  input wire bus_sel,
  input wire bus_wr,
  input wire [31:0] bus_addr,
  input wire [3:0] bus_be,
  input wire [31:0] bus_wdata,
  output reg [31:0] bus_rdata,
  output reg bus_ack,
  output reg bus_err,
  // Counter source ticks, one mclk wide
  input wire fast_src_tick,
  input wire slow_src_tick,
  // Sleep request per instance from the power/clock/reset unit
  input wire [3:0] sleep_req,
  // Waveform pins
  output reg [3:0] pwm_out
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  reg rst_meta_q;
  reg rst_sync_q;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  wire rst_n = rst_sync_q;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire [31:0] rel_addr = bus_addr - `PWMB_BASE;
  wire in_span = (rel_addr[31:`PWMB_SPAN_LSB] == `PWMB_SPAN_ZERO);
  wire [1:0] inst = rel_addr[`PWMB_INST_MSB:`PWMB_INST_LSB];
  wire [3:0] offs = rel_addr[`PWMB_OFF_MSB:0];
  wire sel_high = (offs == `PWMB_OFF_HIGH);
  wire sel_low = (offs == `PWMB_OFF_LOW);
  wire sel_cfg = (offs == `PWMB_OFF_CFG);
  wire hit = in_span && (sel_high || sel_low || sel_cfg);
  wire wr_hit = bus_sel && bus_wr && hit;

  // Read words of all instances, only the addressed one nonzero
  wire [127:0] rword_all;
  wire [3:0] level_all;

  // ----------------------------------------
  // Per-instance registers and sequencing
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `PWMB_NUM_INST; gi = gi + 1) begin : g_ch
      reg [15:0] high_q;
      reg [15:0] high_d;
      reg [15:0] low_q;
      reg [15:0] low_d;
      reg [6:0] cfg_q;
      reg [6:0] cfg_d;
      reg [3:0] div_q;
      reg [3:0] div_d;
      reg tick_q;
      reg tick_d;
      reg [31:0] rword_d;
      wire on_w;
      wire me = (inst == gi);
      wire wr_high = wr_hit && me && sel_high;
      wire wr_low = wr_hit && me && sel_low;
      wire wr_cfg = wr_hit && me && sel_cfg;
      wire enabled = cfg_q[`PWMB_CFG_EN];
      wire [3:0] pre = cfg_q[`PWMB_CFG_PRE_MSB:`PWMB_CFG_PRE_LSB];
      // Slow source when set, fast ring oscillator when clear
      wire src_tick = cfg_q[`PWMB_CFG_CLKSEL] ?
                      slow_src_tick : fast_src_tick;
      wire stop = !enabled || sleep_req[gi];
      wire div_wrap = (div_q >= pre);

      // ----------------------------------------
      // Register writes
      // ----------------------------------------
      // Counts ignore the enable bit; only the bus writes them
      always @* begin
        high_d = high_q;
        if (wr_high && bus_be[`PWMB_BE_B0]) begin
          high_d[`PWMB_BYTE0_MSB:0] = bus_wdata[`PWMB_BYTE0_MSB:0];
        end
        if (wr_high && bus_be[`PWMB_BE_B1]) begin
          high_d[`PWMB_CNT_MSB:`PWMB_BYTE1_LSB] =
            bus_wdata[`PWMB_CNT_MSB:`PWMB_BYTE1_LSB];
        end
      end

      always @* begin
        low_d = low_q;
        if (wr_low && bus_be[`PWMB_BE_B0]) begin
          low_d[`PWMB_BYTE0_MSB:0] = bus_wdata[`PWMB_BYTE0_MSB:0];
        end
        if (wr_low && bus_be[`PWMB_BE_B1]) begin
          low_d[`PWMB_CNT_MSB:`PWMB_BYTE1_LSB] =
            bus_wdata[`PWMB_CNT_MSB:`PWMB_BYTE1_LSB];
        end
      end

      // Config lives in lane 0 only; the upper lanes are reserved
      always @* begin
        cfg_d = cfg_q;
        if (wr_cfg && bus_be[`PWMB_BE_B0]) begin
          cfg_d = bus_wdata[`PWMB_CFG_MSB:0];
        end
      end

      // ----------------------------------------
      // Prescaler
      // ----------------------------------------
      // One tick per pre+1 source ticks; held clear while stopped so a
      // restart always begins with a full division
      always @* begin
        div_d = div_q;
        tick_d = 1'b0;
        if (stop) begin
          div_d = `PWMB_PRE_ZERO;
          tick_d = 1'b0;
        end else if (src_tick) begin
          if (div_wrap) begin
            div_d = `PWMB_PRE_ZERO;
            tick_d = 1'b1;
          end else begin
            div_d = div_q + `PWMB_PRE_ONE;
          end
        end
      end

      // ----------------------------------------
      // Instance state
      // ----------------------------------------
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          high_q <= `PWMB_HIGH_RST;
          low_q <= `PWMB_LOW_RST;
          cfg_q <= `PWMB_CFG_RST;
          div_q <= `PWMB_PRE_ZERO;
          tick_q <= 1'b0;
        end else begin
          high_q <= high_d;
          low_q <= low_d;
          cfg_q <= cfg_d;
          div_q <= div_d;
          tick_q <= tick_d;
        end
      end

      pwmb_engine u_engine (
        .mclk(mclk),
        .rst_n(rst_n),
        .clear(stop),
        .tick(tick_q),
        .high_cnt(high_q),
        .low_cnt(low_q),
        .on_q(on_w)
      );

      // Inactive level follows invert, so a disabled pin still idles right
      assign level_all[gi] = on_w ^ cfg_q[`PWMB_CFG_INVERT];

      // ----------------------------------------
      // Read word
      // ----------------------------------------
      always @* begin
        rword_d = `PWMB_WORD_ZERO;
        if (hit && me) begin
          if (sel_high) begin
            rword_d[`PWMB_CNT_MSB:0] = high_q;
          end else if (sel_low) begin
            rword_d[`PWMB_CNT_MSB:0] = low_q;
          end else begin
            rword_d[`PWMB_CFG_MSB:0] = cfg_q;
          end
        end
      end

      assign rword_all[gi*32 +: 32] = rword_d;
    end
  endgenerate

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  reg [31:0] rd_d;

  // Only the addressed instance offers a nonzero word
  always @* begin
    rd_d = rword_all[inst*32 +: 32];
  end

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  reg ack_d;
  reg err_d;
  reg [31:0] rdata_d;

  // Every access is answered next cycle; misses read zero and flag error
  always @* begin
    ack_d = bus_sel;
    err_d = bus_sel && !hit;
    rdata_d = `PWMB_WORD_ZERO;
    if (bus_sel && !bus_wr) begin
      rdata_d = rd_d;
    end
  end

  // One process for all pins, so no vector has several drivers
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= `PWMB_WORD_ZERO;
      bus_ack <= 1'b0;
      bus_err <= 1'b0;
      pwm_out <= `PWMB_PIN_RST;
    end else begin
      bus_rdata <= rdata_d;
      bus_ack <= ack_d;
      bus_err <= err_d;
      pwm_out <= level_all;
    end
  end

endmodule

// ==== design/pwmb_engine.v ====
// Phase sequencer of one waveform output: down counter and on/off state
`timescale 1ns/1ps
`include "pwmb_consts.vh"

module pwmb_engine (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Control
  input wire clear,
  input wire tick,
  input wire [15:0] high_cnt,
  input wire [15:0] low_cnt,
  // Result
  output reg on_q
);

  localparam [1:0] ST_OFF = 2'b00;
  localparam [1:0] ST_ON_PH = 2'b01;
  localparam [1:0] ST_OFF_PH = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [15:0] cnt_q;
  reg [15:0] cnt_d;
  reg on_d;

  wire full_on = (low_cnt == `PWMB_CNT_ZERO);
  wire full_off = (high_cnt == `PWMB_CNT_ZERO) && !full_on;
  wire last = (cnt_q <= `PWMB_CNT_ONE);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    on_d = on_q;
    if (clear) begin
      state_d = ST_OFF;
      cnt_d = `PWMB_CNT_ZERO;
      on_d = 1'b0;
    end else if (full_on) begin
      state_d = ST_OFF;
      cnt_d = `PWMB_CNT_ZERO;
      on_d = 1'b1;
    end else if (full_off) begin
      state_d = ST_OFF;
      cnt_d = `PWMB_CNT_ZERO;
      on_d = 1'b0;
    end else begin
      case (state_q)
        ST_OFF: begin
          // Start on the on phase so a fresh enable gives a clean pulse
          state_d = ST_ON_PH;
          cnt_d = high_cnt;
          on_d = 1'b1;
        end
        ST_ON_PH: begin
          if (tick) begin
            if (last) begin
              state_d = ST_OFF_PH;
              cnt_d = low_cnt;
              on_d = 1'b0;
            end else begin
              cnt_d = cnt_q - `PWMB_CNT_ONE;
            end
          end
        end
        ST_OFF_PH: begin
          if (tick) begin
            if (last) begin
              state_d = ST_ON_PH;
              cnt_d = high_cnt;
              on_d = 1'b1;
            end else begin
              cnt_d = cnt_q - `PWMB_CNT_ONE;
            end
          end
        end
        default: begin
          state_d = ST_OFF;
          cnt_d = `PWMB_CNT_ZERO;
          on_d = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_OFF;
      cnt_q <= `PWMB_CNT_ZERO;
      on_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      on_q <= on_d;
    end
  end

endmodule

// ==== shared/pwmb_consts.vh ====
// Constants for the four-instance waveform register bank
`ifndef PWMB_CONSTS_VH
`define PWMB_CONSTS_VH

// ----------------------------------------
// Address map
// ----------------------------------------
`define PWMB_BASE 32'h4000_5800
`define PWMB_NUM_INST 4
`define PWMB_INST_W 2
`define PWMB_INST_LSB 4
`define PWMB_INST_MSB 5
`define PWMB_OFF_MSB 3
`define PWMB_SPAN_LSB 6
`define PWMB_SPAN_ZERO 26'h000_0000
`define PWMB_OFF_HIGH 4'h0
`define PWMB_OFF_LOW 4'h4
`define PWMB_OFF_CFG 4'h8

// ----------------------------------------
// Field layout
// ----------------------------------------
`define PWMB_CNT_W 16
`define PWMB_CFG_W 7
`define PWMB_CFG_EN 0
`define PWMB_CFG_CLKSEL 1
`define PWMB_CFG_INVERT 2
`define PWMB_CFG_PRE_LSB 3
`define PWMB_CFG_PRE_MSB 6
`define PWMB_PRE_W 4
`define PWMB_CNT_MSB 15
`define PWMB_CFG_MSB 6
`define PWMB_BYTE0_MSB 7
`define PWMB_BYTE1_LSB 8
`define PWMB_BE_B0 0
`define PWMB_BE_B1 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PWMB_HIGH_RST 16'h0000
`define PWMB_LOW_RST 16'hffff
`define PWMB_CFG_RST 7'h00
`define PWMB_PRE_ZERO 4'h0
`define PWMB_PRE_ONE 4'h1
`define PWMB_CNT_ZERO 16'h0000
`define PWMB_CNT_ONE 16'h0001
`define PWMB_WORD_ZERO 32'h0000_0000
`define PWMB_PIN_RST 4'h0

`endif

// ==== sim/pwmb_bank_monitor.sv ====
// Checker of bus answers and pin behaviour of the bank
`timescale 1ns/1ps
module pwmb_bank_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Register port
  input wire logic bus_sel,
  input wire logic bus_wr,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_ack,
  input wire logic bus_err,
  // Pins
  input wire logic [3:0] sleep_req,
  input wire logic [3:0] pwm_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_ack; bus_sel |=> bus_ack; endproperty
  property p_no_ack; !bus_sel |=> !bus_ack; endproperty
  property p_hole; bus_sel && bus_addr[3:0] == 4'hc |=> bus_err;
  endproperty
  property p_span; bus_sel && bus_addr[31:6] != 26'h100_0160
    |=> bus_err; endproperty
  property p_in_map; bus_sel && bus_addr[31:6] == 26'h100_0160 &&
    bus_addr[3:0] != 4'hc && bus_addr[1:0] == 2'h0 |=> !bus_err;
  endproperty
  property p_idle; !bus_ack |-> bus_rdata == 32'h0; endproperty
  property p_upper; bus_ack |-> bus_rdata[31:16] == 16'h0; endproperty
  property p_cfg; bus_sel && !bus_wr && bus_addr[3:0] == 4'h8
    |=> bus_rdata[31:7] == 25'h0; endproperty
  // A config write may move the inactive level, so skip those windows
  property p_sleep; (sleep_req[0] && !(bus_sel && bus_wr)) [*4]
    |-> $stable(pwm_out[0]); endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  a_no_ack: assert property (p_no_ack) else $error("stray ack");
  a_hole: assert property (p_hole) else $error("hole no err");
  a_span: assert property (p_span) else $error("span no err");
  a_in_map: assert property (p_in_map) else $error("bad err");
  a_idle: assert property (p_idle) else $error("rdata idle");
  a_upper: assert property (p_upper) else $error("rdata top");
  a_cfg: assert property (p_cfg) else $error("cfg top");
  a_sleep: assert property (p_sleep) else $error("sleep pin");
  c_err: cover property (bus_err);
  c_data: cover property (bus_ack && bus_rdata != 32'h0);
  c_sleep: cover property (sleep_req[0] [*4]);
endmodule

// ==== sim/pwmb_bank_tb.sv ====
// Self-checking bench for the waveform register bank
`timescale 1ns/1ps
`include "pwmb_consts.vh"
module pwmb_bank_tb;
  logic mclk = 0, arst_n = 0, sel = 0, wr = 0, fast = 0, slow = 0;
  logic [31:0] addr = 0, wdata = 0, rdata, rd;
  logic [3:0] sleep = 0, pwm, be = 4'hf;
  logic ack, err, e;
  logic [15:0] hi_run, lo_run, cur_run;
  int bad_count = 0, n_compared = 0;
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) slow <= #1 ~slow;
  pwmb_bank i_dut (.mclk(mclk), .arst_n(arst_n), .bus_sel(sel),
    .bus_wr(wr), .bus_addr(addr), .bus_be(be), .bus_wdata(wdata),
    .bus_rdata(rdata), .bus_ack(ack), .bus_err(err),
    .fast_src_tick(fast), .slow_src_tick(slow), .sleep_req(sleep),
    .pwm_out(pwm));
  pwmb_load_model i_load (.mclk(mclk), .pin(pwm[0]), .hi_run(hi_run),
    .lo_run(lo_run), .cur_run(cur_run));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] ad(input int i, input logic [3:0] o);
    return `PWMB_BASE + 32'(i) * 32'h10 + {28'h0, o};
  endfunction
  // Answer is registered at the taking edge and read 1 ns after it
  task automatic acc(input logic w, input logic [31:0] a, d);
    @(posedge mclk);
    #1;
    sel = 1;
    wr = w;
    addr = a;
    wdata = d;
    @(posedge mclk);
    #1;
    sel = 0;
    chk(ack, 1);
    rd = rdata;
    e = err;
  endtask
  task automatic rchk(input int i, input logic [3:0] o, logic [31:0] x);
    acc(0, ad(i, o), 0);
    chk(rd, x);
  endtask
  task automatic prog(input logic [15:0] h, l, input logic [31:0] c);
    acc(1, ad(0, 4'h8), 0);
    acc(1, ad(0, 4'h0), {16'h0, h});
    acc(1, ad(0, 4'h4), {16'h0, l});
    acc(1, ad(0, 4'h8), c);
    repeat (60) @(posedge mclk);
    #1;
  endtask
  task automatic wave(input logic [15:0] h, l, input logic [31:0] c,
      input logic [15:0] eh, el);
    prog(h, l, c);
    chk(hi_run, eh);
    chk(lo_run, el);
    $display("test wave %h done", c);
  endtask
  // Level held: no toggle seen for more than 30 cycles
  task automatic hold(input logic [15:0] h, l, input logic [31:0] c,
      input logic v);
    prog(h, l, c);
    chk(pwm[0], v);
    chk(cur_run > 16'd30, 1);
    chk(pwm[3:1], 3'h0);
    $display("test hold %h done", c);
  endtask
  task automatic complete_run();
    $display("compared %0d, wrong %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge mclk);
    #1 arst_n = 1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      rchk(i, 4'h0, 32'h0);
      rchk(i, 4'h4, 32'hffff);
      rchk(i, 4'h8, 32'h0);
    end
    acc(1, ad(3, 4'h0), 32'hffff_1234);
    rchk(3, 4'h0, 32'h1234);
    be = 4'h2;
    acc(1, ad(3, 4'h0), 32'h0000_ab56);
    be = 4'hf;
    rchk(3, 4'h0, 32'hab34);
    rchk(2, 4'h0, 32'h0);
    acc(1, ad(3, 4'h8), 32'hffff_fff8);
    rchk(3, 4'h8, 32'h78);
    acc(0, ad(1, 4'hc), 0);
    chk(e, 1);
    chk(rd, 0);
    acc(0, ad(4, 4'h0), 0);
    chk(e, 1);
    $display("test registers done");
    fast = 1;
    wave(2, 3, 32'h1, 2, 3);
    wave(2, 3, 32'h5, 3, 2);
    wave(2, 3, 32'h9, 4, 6);
    wave(2, 3, 32'h3, 4, 6);
    hold(0, 5, 32'h1, 0);
    hold(7, 0, 32'h1, 1);
    hold(2, 3, 32'h4, 1);
    rchk(0, 4'h0, 32'h2);
    rchk(0, 4'h4, 32'h3);
    sleep = 4'h1;
    hold(2, 3, 32'h1, 0);
    sleep = 0;
    complete_run();
  end
endmodule
bind pwmb_bank pwmb_bank_monitor i_mon (.mclk(mclk), .arst_n(arst_n),
  .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_addr(bus_addr),
  .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err),
  .sleep_req(sleep_req), .pwm_out(pwm_out));

// ==== sim/pwmb_load_model.sv ====
// Load on one waveform pin: measures level run lengths
`timescale 1ns/1ps
module pwmb_load_model (
  // Clock
  input wire logic mclk,
  // Pin
  input wire logic pin,
  // Last high and low runs, run in progress
  output logic [15:0] hi_run,
  output logic [15:0] lo_run,
  output logic [15:0] cur_run
);
  logic last;
  initial begin
    last = 0;
    hi_run = 0;
    lo_run = 0;
    cur_run = 0;
  end
  always @(posedge mclk) begin
    if (pin !== last) begin
      if (last)
        hi_run <= cur_run;
      else
        lo_run <= cur_run;
      cur_run <= 16'h1;
    end else
      cur_run <= cur_run + 16'h1;
    last <= pin;
  end
endmodule
